// >>> verilog/cascadable_dual_timer_pair.sv
module cascadable_dual_timer_pair (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   input  wire logic [7:0]  ext_clk_pin,
   input  wire logic [7:0]  ext_gate_pin,
   output logic      [15:0] reg_rdata,
   output logic             irq,
   output logic      [7:0]  irq_request,
   output logic      [23:0] irq_level,
   output logic             adc1_trigger,
   output logic             adc2_trigger,
   output logic      [15:0] capture_base_even,
   output logic      [15:0] capture_base_odd
);

   // Two-stage synchronisers for the pins; stage one feeds stage two only.
   logic [7:0] clk_meta, clk_sync, clk_prev, gate_meta, gate_sync;
   logic [7:0] next_clk_meta, next_clk_sync, next_clk_prev;
   logic [7:0] next_gate_meta, next_gate_sync;

   always_comb begin
      next_clk_meta  = ext_clk_pin;
      next_clk_sync  = clk_meta;
      next_clk_prev  = clk_sync;
      next_gate_meta = ext_gate_pin;
      next_gate_sync = gate_meta;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         clk_meta  <= 8'h00;
         clk_sync  <= 8'h00;
         clk_prev  <= 8'h00;
         gate_meta <= 8'h00;
         gate_sync <= 8'h00;
      end else begin
         clk_meta  <= next_clk_meta;
         clk_sync  <= next_clk_sync;
         clk_prev  <= next_clk_prev;
         gate_meta <= next_gate_meta;
         gate_sync <= next_gate_sync;
      end
   end

   function automatic logic [7:0] ps_limit(input logic [1:0] sel);
      unique case (sel)
         2'h0: ps_limit = timer_pair_pkg::PS_DIV1;
         2'h1: ps_limit = timer_pair_pkg::PS_DIV8;
         2'h2: ps_limit = timer_pair_pkg::PS_DIV64;
         2'h3: ps_limit = timer_pair_pkg::PS_DIV256;
      endcase
   endfunction

   function automatic timer_pair_pkg::timer_ctrl_t unpack_ctrl(
      input logic [15:0] w);
      unpack_ctrl.timer_on                = w[timer_pair_pkg::CTRL_ON];
      unpack_ctrl.gated_accumulate_enable = w[timer_pair_pkg::CTRL_GATE];
      unpack_ctrl.prescale_select =
         w[timer_pair_pkg::CTRL_PS_HI:timer_pair_pkg::CTRL_PS_LO];
      unpack_ctrl.pair_chain_enable       = w[timer_pair_pkg::CTRL_CHAIN];
      unpack_ctrl.clock_source_select     = w[timer_pair_pkg::CTRL_CS];
   endfunction

   timer_pair_pkg::timer_ctrl_t ctrl [8];
   timer_pair_pkg::irq_cfg_t    icfg [8];
   logic [15:0] period_value [8];
   logic [15:0] count [8];
   logic [7:0]  ps_cnt [8];
   logic [7:0]  status, mask;

   timer_pair_pkg::timer_ctrl_t next_ctrl [8];
   timer_pair_pkg::irq_cfg_t    next_icfg [8];
   logic [15:0] next_period [8];
   logic [15:0] next_count [8];
   logic [7:0]  next_ps_cnt [8];
   logic [7:0]  next_status, next_mask;
   logic [15:0] next_rdata;
   logic [7:0]  tick, match;
   logic        next_irq, next_adc1, next_adc2;
   logic [7:0]  next_irq_request;
   logic [23:0] next_irq_level;

   logic [2:0]  sel_t;
   logic [7:0]  sel_off;
   logic        sel_timer;

   always_comb begin
      sel_t     = reg_addr[4:2];
      sel_off   = {6'h00, reg_addr[1:0]};
      sel_timer = (reg_addr[7:5] == 3'h0);
   end

   // Each pair sees its even timer's settings; the odd timer's are bypassed
   // while chained, so one clock, gate and prescaler drive both words.
   for (genvar p = 0; p < timer_pair_pkg::NUM_PAIRS; p++) begin : g_pair
      localparam int E = 2 * p;
      localparam int O = 2 * p + 1;
      logic chain, run_e, run_o, pulse_e, pulse_o, m32, m16e, m16o;
      logic [31:0] cnt32, per32;
      // Pair-local copies keep each bit of the shared vectors to one driver.
      logic tick_e, tick_o, match_e, match_o;
      assign tick[E]  = tick_e;
      assign tick[O]  = tick_o;
      assign match[E] = match_e;
      assign match[O] = match_o;
      always_comb begin
         chain = ctrl[E].pair_chain_enable;
         cnt32 = {count[O], count[E]};
         per32 = {period_value[O], period_value[E]};
         pulse_e = ctrl[E].clock_source_select ?
                   (clk_sync[E] & ~clk_prev[E]) : 1'b1;
         pulse_o = ctrl[O].clock_source_select ?
                   (clk_sync[O] & ~clk_prev[O]) : 1'b1;
         // Gated accumulation counts the selected clock, internal or external, only while the gate is high.
         run_e = ctrl[E].timer_on & pulse_e &
                 (~ctrl[E].gated_accumulate_enable | gate_sync[E]);
         run_o = chain ? 1'b0 : (ctrl[O].timer_on & pulse_o &
                 (~ctrl[O].gated_accumulate_enable | gate_sync[O]));
         tick_e = run_e & (ps_cnt[E] == ps_limit(ctrl[E].prescale_select));
         tick_o = run_o & (ps_cnt[O] == ps_limit(ctrl[O].prescale_select));
         m32  = (cnt32 == per32);
         m16e = (count[E] == period_value[E]);
         m16o = (count[O] == period_value[O]);
         match_e = ~chain & tick_e & m16e;
         match_o = chain ? (tick_e & m32) : (tick_o & m16o);
         next_ps_cnt[E] = ps_cnt[E];
         next_ps_cnt[O] = ps_cnt[O];
         if (run_e) begin
            next_ps_cnt[E] = tick_e ? 8'h00 : ps_cnt[E] + 8'h01;
         end
         if (run_o) begin
            next_ps_cnt[O] = tick_o ? 8'h00 : ps_cnt[O] + 8'h01;
         end
         next_count[E] = count[E];
         next_count[O] = count[O];
         if (chain && tick_e) begin
            {next_count[O], next_count[E]} = m32 ? 32'h0 : cnt32 + 32'h1;
         end else begin
            if (tick_e) begin
               next_count[E] = m16e ? 16'h0000 : count[E] + 16'h0001;
            end
            if (tick_o) begin
               next_count[O] = m16o ? 16'h0000 : count[O] + 16'h0001;
            end
         end
         // Software writes to a count override the advance in the same cycle.
         if (reg_write && sel_timer && sel_off == timer_pair_pkg::OFF_COUNT) begin
            if (sel_t == 3'(E)) begin
               next_count[E] = reg_wdata;
            end
            if (sel_t == 3'(O)) begin
               next_count[O] = reg_wdata;
            end
         end
      end
   end

   // Register writes, status, read-back and interrupt outputs.
   always_comb begin
      next_mask   = mask;
      next_status = status | match;
      for (int i = 0; i < timer_pair_pkg::NUM_TIMERS; i++) begin
         next_ctrl[i]   = ctrl[i];
         next_icfg[i]   = icfg[i];
         next_period[i] = period_value[i];
         if (reg_write && sel_timer && sel_t == 3'(i)) begin
            unique case (sel_off)
               timer_pair_pkg::OFF_CTRL:    next_ctrl[i] = unpack_ctrl(reg_wdata);
               timer_pair_pkg::OFF_PERIOD:  next_period[i] = reg_wdata;
               timer_pair_pkg::OFF_IRQ_CFG: next_icfg[i] = reg_wdata[3:0];
               default: ;
            endcase
         end
      end
      if (reg_write && reg_addr == timer_pair_pkg::OFF_MASK) begin
         next_mask = reg_wdata[7:0];
      end
      // A read clears the status, but an event in the same cycle survives.
      if (reg_read && reg_addr == timer_pair_pkg::OFF_STATUS) begin
         next_status = match;
      end
      next_rdata = 16'h0000;
      if (reg_read) begin
         if (sel_timer) begin
            unique case (sel_off)
               timer_pair_pkg::OFF_CTRL: next_rdata = {ctrl[sel_t].timer_on,
                  8'h00, ctrl[sel_t].gated_accumulate_enable,
                  ctrl[sel_t].prescale_select, ctrl[sel_t].pair_chain_enable,
                  1'b0, ctrl[sel_t].clock_source_select, 1'b0};
               timer_pair_pkg::OFF_PERIOD:  next_rdata = period_value[sel_t];
               timer_pair_pkg::OFF_COUNT:   next_rdata = count[sel_t];
               timer_pair_pkg::OFF_IRQ_CFG: next_rdata = {12'h000, icfg[sel_t]};
               default: next_rdata = 16'h0000;
            endcase
         end else if (reg_addr == timer_pair_pkg::OFF_STATUS) begin
            next_rdata = {8'h00, status};
         end else if (reg_addr == timer_pair_pkg::OFF_MASK) begin
            next_rdata = {8'h00, mask};
         end
      end
      for (int i = 0; i < timer_pair_pkg::NUM_TIMERS; i++) begin
         next_irq_request[i] = status[i] & icfg[i].timer_irq_enable;
         next_irq_level[3*i +: 3] = icfg[i].timer_irq_priority;
      end
      next_irq  = |(status & mask);
      next_adc1 = match[1] | match[0];
      next_adc2 = match[3] | match[2];
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         for (int i = 0; i < timer_pair_pkg::NUM_TIMERS; i++) begin
            ctrl[i]         <= timer_pair_pkg::timer_ctrl_t'(6'h00);
            icfg[i]         <= timer_pair_pkg::RST_IRQCFG;
            period_value[i] <= timer_pair_pkg::RST_PERIOD;
            count[i]        <= timer_pair_pkg::RST_COUNT;
            ps_cnt[i]       <= 8'h00;
         end
         status            <= 8'h00;
         mask              <= timer_pair_pkg::RST_MASK;
         reg_rdata         <= 16'h0000;
         irq               <= 1'b0;
         irq_request       <= 8'h00;
         irq_level         <= 24'h000000;
         adc1_trigger      <= 1'b0;
         adc2_trigger      <= 1'b0;
         capture_base_even <= 16'h0000;
         capture_base_odd  <= 16'h0000;
      end else begin
         for (int i = 0; i < timer_pair_pkg::NUM_TIMERS; i++) begin
            ctrl[i]         <= next_ctrl[i];
            icfg[i]         <= next_icfg[i];
            period_value[i] <= next_period[i];
            count[i]        <= next_count[i];
            ps_cnt[i]       <= next_ps_cnt[i];
         end
         status            <= next_status;
         mask              <= next_mask;
         reg_rdata         <= next_rdata;
         irq               <= next_irq;
         irq_request       <= next_irq_request;
         irq_level         <= next_irq_level;
         adc1_trigger      <= next_adc1;
         adc2_trigger      <= next_adc2;
         capture_base_even <= next_count[0];
         capture_base_odd  <= next_count[1];
      end
   end

   chk_chain_wrap: assert property (@(posedge sys_clk) disable iff (rst)
      (ctrl[0].pair_chain_enable && tick[0] && g_pair[0].m32)
      |=> (count[0] == 16'h0000 && count[1] == 16'h0000 && status[1]))
      else $error("chained pair did not wrap with flag");

   chk_odd_ignored: assert property (@(posedge sys_clk) disable iff (rst)
      (ctrl[0].pair_chain_enable) |-> (tick[1] == 1'b0 && match[0] == 1'b0))
      else $error("odd timer advanced alone while chained");

   chk_off_hold: assert property (@(posedge sys_clk) disable iff (rst)
      (!ctrl[2].timer_on && !ctrl[2].pair_chain_enable && !reg_write)
      |=> $stable(count[2]))
      else $error("count moved with timer off");

   chk_adc_trig: assert property (@(posedge sys_clk) disable iff (rst)
      (match[0] || match[1]) |=> adc1_trigger)
      else $error("converter trigger missed");

   chk_irq_out: assert property (@(posedge sys_clk) disable iff (rst)
      (|(status & mask)) |=> irq)
      else $error("interrupt output missed");

   chk_prescale: assert property (@(posedge sys_clk) disable iff (rst)
      tick[4] |-> (ps_cnt[4] == ps_limit(ctrl[4].prescale_select)))
      else $error("prescaler tick early");

   chk_low_carry: assert property (@(posedge sys_clk) disable iff (rst)
      (ctrl[2].pair_chain_enable && tick[2] && !g_pair[1].m32 &&
       count[2] == 16'hffff && !reg_write) |=> (count[2] == 16'h0000 &&
       count[3] == $past(count[3]) + 16'h0001))
      else $error("low word carry lost");

   chk_sticky: assert property (@(posedge sys_clk) disable iff (rst)
      (match[1] && !reg_read) |=> status[1] [*1])
      else $error("status not set on match");

endmodule

// >>> shared/timer_pair_pkg.sv
package timer_pair_pkg;

   localparam int         NUM_PAIRS   = 4;
   localparam int         NUM_TIMERS  = 8;
   localparam logic [3:0] ADDR_W      = 4'h0;

   // Register offsets; index is the register address on the plain port.
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_PERIOD   = 8'h01;
   localparam logic [7:0] OFF_COUNT    = 8'h02;
   localparam logic [7:0] OFF_IRQ_CFG  = 8'h03;
   localparam logic [7:0] OFF_STATUS   = 8'h20;
   localparam logic [7:0] OFF_MASK     = 8'h21;
   localparam int         TIMER_STRIDE = 4;

   // Control word field positions.
   localparam int CTRL_ON      = 15;
   localparam int CTRL_GATE    = 6;
   localparam int CTRL_PS_HI   = 5;
   localparam int CTRL_PS_LO   = 4;
   localparam int CTRL_CHAIN   = 3;
   localparam int CTRL_CS      = 1;

   // Interrupt configuration field positions.
   localparam int IRQ_EN       = 3;
   localparam int IRQ_PRI_HI   = 2;

   localparam logic [15:0] RST_CTRL   = 16'h0000;
   localparam logic [15:0] RST_PERIOD = 16'hffff;
   localparam logic [15:0] RST_COUNT  = 16'h0000;
   localparam logic [3:0]  RST_IRQCFG = 4'h0;
   localparam logic [7:0]  RST_MASK   = 8'h00;

   // Prescale terminal counts for ratios 1, 8, 64 and 256.
   localparam logic [7:0] PS_DIV1   = 8'h00;
   localparam logic [7:0] PS_DIV8   = 8'h07;
   localparam logic [7:0] PS_DIV64  = 8'h3f;
   localparam logic [7:0] PS_DIV256 = 8'hff;

   typedef struct packed {
      logic        timer_on;
      logic        gated_accumulate_enable;
      logic [1:0]  prescale_select;
      logic        pair_chain_enable;
      logic        clock_source_select;
   } timer_ctrl_t;

   typedef struct packed {
      logic        timer_irq_enable;
      logic [2:0]  timer_irq_priority;
   } irq_cfg_t;

endpackage

// >>> bench/cascadable_dual_timer_pair_tb.sv
module cascadable_dual_timer_pair_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk, rst, reg_write, reg_read, irq;
   logic        adc1_trigger, adc2_trigger;
   logic [7:0]  reg_addr, ext_clk_pin, ext_gate_pin, irq_request;
   logic [15:0] reg_wdata, reg_rdata, capture_base_even, capture_base_odd;
   logic [23:0] irq_level;
   logic [15:0] a, b;
   int          fail_count, compares, cycles, seed, t0, t1, lat;
   int          ratio [4] = '{1, 8, 64, 256};
   int          model_period [8];

   cascadable_dual_timer_pair u_cascadable_dual_timer_pair (
      .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
      .ext_clk_pin, .ext_gate_pin, .reg_rdata, .irq, .irq_request,
      .irq_level, .adc1_trigger, .adc2_trigger, .capture_base_even,
      .capture_base_odd);

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // A hang in any wait ends the run here instead of stalling forever.
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Each access is followed by an idle cycle so no strobe is driven twice
   // in one time step.
   task automatic wr(input logic [7:0] ad, input logic [15:0] d);
      reg_addr  <= ad;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic rd(input logic [7:0] ad, output logic [15:0] d);
      reg_addr <= ad;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
      @(posedge sys_clk);
   endtask

   task automatic rchk(input logic [7:0] ad, input logic [15:0] e);
      logic [15:0] d;
      rd(ad, d);
      chk(d, e);
   endtask

   task automatic trig(input bit two, output int t);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         #1 n++;
      end while ((two ? adc2_trigger : adc1_trigger) !== 1'b1 && n < 3000);
      t = cycles;
      @(posedge sys_clk);
   endtask

   initial begin
      seed = 32'h2d82;
      rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
      ext_clk_pin = 8'h00;
      ext_gate_pin = 8'h00;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
         rchk(8'(4 * i), 16'h0000);
         rchk(8'(4 * i + 1), 16'hffff);
         rchk(8'(4 * i + 2), 16'h0000);
         rchk(8'(4 * i + 3), 16'h0000);
         model_period[i] = $random(seed) & 32'hffff;
         a = 16'($random(seed)) & 16'h000f;
         wr(8'(4 * i + 1), 16'(model_period[i]));
         wr(8'(4 * i + 3), a);
         rchk(8'(4 * i + 1), 16'(model_period[i]));
         rchk(8'(4 * i + 3), a);
         chk(irq_level[3 * i +: 3], a[2:0]);
      end
      rchk(8'h20, 16'h0000);
      rchk(8'h21, 16'h0000);
      wr(8'h30, 16'ha5a5);
      rchk(8'h30, 16'h0000);
      $display("test registers done");
      wr(8'h01, 16'hffff);
      wr(8'h00, 16'h0070);
      repeat (20) @(posedge sys_clk);
      rchk(8'h02, 16'h0000);
      wr(8'h00, 16'h8000);
      rd(8'h02, a);
      rd(8'h02, b);
      chk(16'(b - a), 32'd2);
      wr(8'h00, 16'h0000);
      rd(8'h02, a);
      chk(capture_base_even, a);
      $display("test internal clock done");
      wr(8'h11, 16'hffff);
      wr(8'h10, 16'h8040);
      rd(8'h12, a);
      rd(8'h12, b);
      chk(16'(b - a), 32'd0);
      ext_gate_pin[4] <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rd(8'h12, a);
      rd(8'h12, b);
      chk(16'(b - a), 32'd2);
      wr(8'h15, 16'hffff);
      wr(8'h14, 16'h8002);
      for (int k = 0; k < 6; k++) begin
         ext_clk_pin[5] <= 1'b1;
         repeat (3) @(posedge sys_clk);
         ext_clk_pin[5] <= 1'b0;
         repeat (3) @(posedge sys_clk);
      end
      repeat (4) @(posedge sys_clk);
      rchk(8'h16, 16'h0006);
      $display("test gate and external clock done");
      // The odd control is loaded with a running setup that must be ignored.
      wr(8'h00, 16'h0008);
      // A low word left above the period would need a full 32-bit wrap.
      wr(8'h02, 16'h0000);
      wr(8'h01, 16'h0004);
      wr(8'h05, 16'h0000);
      wr(8'h04, 16'h80b0);
      wr(8'h07, 16'h000d);
      wr(8'h21, 16'h0002);
      for (int p = 0; p < 4; p++) begin
         wr(8'h00, 16'h8008 | 16'(p << 4));
         trig(1'b0, t0);
         trig(1'b0, t1);
         chk(t1 - t0, 5 * ratio[p]);
         wr(8'h00, 16'h0008);
      end
      #1 chk(irq, 1'b1);
      chk(irq_request[1:0], 2'b10);
      chk(irq_level[5:3], 3'h5);
      @(posedge sys_clk);
      rchk(8'h20, 16'h0002);
      repeat (2) @(posedge sys_clk);
      #1 chk(irq, 1'b0);
      @(posedge sys_clk);
      rd(8'h06, a);
      chk(capture_base_odd, a);
      $display("test chained prescale done");
      wr(8'h08, 16'h0008);
      wr(8'h09, 16'h0004);
      wr(8'h0d, 16'h0000);
      wr(8'h0a, 16'h0000);
      wr(8'h0e, 16'h0000);
      t0 = cycles;
      wr(8'h08, 16'h8008);
      trig(1'b1, t1);
      lat = t1 - t0;
      wr(8'h08, 16'h0008);
      wr(8'h09, 16'h0002);
      wr(8'h0d, 16'h0001);
      wr(8'h0a, 16'hfff0);
      wr(8'h0e, 16'h0000);
      t0 = cycles;
      wr(8'h08, 16'h8008);
      trig(1'b1, t1);
      // Crossing the low word proves the carry into the high word.
      chk(t1 - t0, lat + 14);
      wr(8'h08, 16'h0008);
      $display("test chained carry done");
      tally_and_finish();
   end
endmodule
